//--- core/evs_vector_select.v
// exception cause detection, priority choice and handler address
`timescale 1ns/100ps
`include "evs_map.vh"
module evs_vector_select #(
  parameter DEC_W = 32
) (
  input  wire             aclk,
  input  wire             aresetn,
  // register bus
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output wire [1:0]       s_axi_bresp,
  output wire             s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output wire [31:0]      s_axi_rdata,
  output wire [1:0]       s_axi_rresp,
  output wire             s_axi_rvalid,
  input  wire             s_axi_rready,
  // outside pins
  input  wire             ext_irq_n,
  input  wire             transfer_error_ack_n,
  input  wire             mask_ext_bp,
  input  wire             devport_bp,
  // pipeline, one-cycle qualifiers
  input  wire             instr_valid,
  input  wire             is_float_ldst,
  input  wire             is_ldst_multiple,
  input  wire             is_string,
  input  wire             is_reserving_load_instr,
  input  wire             is_cond_store,
  input  wire             operand_word_misaligned,
  input  wire             operand_le_misaligned,
  input  wire             is_float_instr,
  input  wire             float_state_move,
  input  wire             is_privileged,
  input  wire             spr_move,
  input  wire             spr_invalid,
  input  wire             spr_unimpl,
  input  wire [9:0]       special_register_number_field,
  input  wire             trap_cond_true,
  input  wire             is_system_call_instr,
  input  wire             instr_completed,
  input  wire             is_intr_return,
  input  wire             is_branch,
  input  wire             float_assist_cond,
  input  wire             unimpl_instr,
  input  wire             data_bp_match,
  input  wire             instr_bp_match,
  input  wire             float_summary_enabled_flag,
  input  wire [DEC_W-1:0] down_counter_reg,
  // exception result
  output reg              take_ff,
  output reg  [31:0]      handler_addr_ff,
  output reg  [1:0]       program_type_ff,
  output reg  [31:0]      machine_state_word_ff
);
  // ======================================================================
  // machine state word bit positions kept here (block-local)
  localparam MSW_GATE  = 15;  // async_interrupt_gate_bit
  localparam MSW_USER  = 14;  // user_mode_bit
  localparam MSW_FAVL  = 13;  // float_available_bit
  localparam MSW_FEA   = 11;  // float_exc_mode_bit_a
  localparam MSW_SSTEP = 10;  // single_step_trace_bit
  localparam MSW_BTR   = 9;   // branch_trace_bit
  localparam MSW_FEB   = 8;   // float_exc_mode_bit_b
  localparam MSW_VBASE = 6;   // vector_base_select_bit
  localparam MSW_RECOV = 1;   // recoverable_state_bit
  localparam MSW_LE    = 0;   // little-endian mode
  localparam NC        = `EVS_NCAUSE;

  // ======================================================================
  // pins from outside the clock domain
  wire [3:0] pin_sync;
  evs_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({~ext_irq_n, ~transfer_error_ack_n, mask_ext_bp, devport_bp}),
    .sync_out (pin_sync)
  );
  wire ext_req    = pin_sync[3];
  wire tea_req    = pin_sync[2];
  wire mbp_req    = pin_sync[1];
  wire devbp_req  = pin_sync[0];

  // ======================================================================
  // register slave; a control write that changes the value loads the machine state word bits, except gate and recoverable, which a take in the same cycle clears
  wire [4:0]  ctrl_w;
  reg  [31:0] take_cnt_ff;
  reg         pend_ext_ff;
  reg         pend_dec_ff;
  reg  [4:0]  ctrl_prev_ff;
  // status: [20] pend dec, [19] pend ext, [18:17] program type, [15:0] state word
  wire [31:0] status_w = {11'h000, pend_dec_ff, pend_ext_ff, program_type_ff, 1'b0,
                          machine_state_word_ff[15:0]};

  evs_axil_slave u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ctrl_ff       (ctrl_w),
    .status_in     (status_w),
    .addr_in       (handler_addr_ff),
    .count_in      (take_cnt_ff)
  );

  // ======================================================================
  // decrementer msb edge
  reg dec_msb_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      dec_msb_ff <= 1'b0;
    end else begin
      dec_msb_ff <= down_counter_reg[DEC_W-1];
    end
  end
  wire dec_rise = down_counter_reg[DEC_W-1] && !dec_msb_ff;

  // ======================================================================
  // cause detection
  wire [31:0] msw     = machine_state_word_ff;
  wire        le_mode = msw[MSW_LE];
  wire        user    = msw[MSW_USER];
  wire        fe_any  = msw[MSW_FEA] | msw[MSW_FEB];
  wire        iv      = instr_valid;

  wire c_align = iv && operand_word_misaligned &&
                 (is_float_ldst || is_ldst_multiple || is_reserving_load_instr || is_cond_store);
  wire c_align_le = iv && le_mode && (operand_le_misaligned || is_ldst_multiple || is_string);
  wire c_pfloat = iv && float_state_move && fe_any && float_summary_enabled_flag;
  wire c_priv = iv && user && (is_privileged ||
                (spr_move && spr_invalid && special_register_number_field[9]));
  wire c_trap = iv && trap_cond_true;
  wire c_fpun = iv && is_float_instr && !msw[MSW_FAVL];
  wire c_sc = iv && is_system_call_instr;
  wire c_trace = instr_completed && ((msw[MSW_SSTEP] && !is_intr_return) ||
                 (msw[MSW_BTR] && is_branch));
  wire c_assist = iv && float_assist_cond && !c_pfloat;
  wire c_emul = iv && (unimpl_instr || (spr_move && spr_unimpl));
  wire recov = msw[MSW_RECOV];

  // pending async causes, held while gate is clear
  wire gate = msw[MSW_GATE];
  wire [NC-1:0] cause;
  assign cause[`EVS_C_RESET]     = 1'b0;          // reset handled by its own path
  assign cause[`EVS_C_NMEXT_BP]  = devbp_req;
  assign cause[`EVS_C_MCHECK]    = tea_req;
  assign cause[`EVS_C_INSTR_BP]  = instr_bp_match && recov;
  assign cause[`EVS_C_DATA_BP]   = data_bp_match && recov;
  assign cause[`EVS_C_MEXT_BP]   = mbp_req && recov;
  assign cause[`EVS_C_SW_EMUL]   = c_emul;
  assign cause[`EVS_C_ALIGN]     = c_align || c_align_le;
  assign cause[`EVS_C_PROGRAM]   = c_pfloat || c_priv || c_trap;
  assign cause[`EVS_C_FP_UNAV]   = c_fpun;
  assign cause[`EVS_C_SYSCALL]   = c_sc;
  assign cause[`EVS_C_FP_ASSIST] = c_assist;
  assign cause[`EVS_C_TRACE]     = c_trace;
  assign cause[`EVS_C_DECR]      = (pend_dec_ff || dec_rise) && gate;
  assign cause[`EVS_C_EXT]       = (pend_ext_ff || ext_req) && gate;

  // ======================================================================
  // fixed priority, lowest index wins
  reg [3:0]  win_idx;
  reg        win_any;
  integer    ci;
  always @* begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (ci = NC - 1; ci >= 0; ci = ci - 1) begin
      if (cause[ci]) begin
        win_idx = ci[3:0];
        win_any = 1'b1;
      end
    end
  end

  // offset table; reserved offsets have no entry
  reg [19:0] win_off;
  always @* begin
    case (win_idx)
      `EVS_C_RESET:     win_off = `EVS_OFF_RESET;
      `EVS_C_NMEXT_BP:  win_off = `EVS_OFF_NMEXT_BP;
      `EVS_C_MCHECK:    win_off = `EVS_OFF_MCHECK;
      `EVS_C_INSTR_BP:  win_off = `EVS_OFF_INSTR_BP;
      `EVS_C_DATA_BP:   win_off = `EVS_OFF_DATA_BP;
      `EVS_C_MEXT_BP:   win_off = `EVS_OFF_MEXT_BP;
      `EVS_C_SW_EMUL:   win_off = `EVS_OFF_SW_EMUL;
      `EVS_C_ALIGN:     win_off = `EVS_OFF_ALIGN;
      `EVS_C_PROGRAM:   win_off = `EVS_OFF_PROGRAM;
      `EVS_C_FP_UNAV:   win_off = `EVS_OFF_FP_UNAV;
      `EVS_C_SYSCALL:   win_off = `EVS_OFF_SYSCALL;
      `EVS_C_FP_ASSIST: win_off = `EVS_OFF_FP_ASSIST;
      `EVS_C_TRACE:     win_off = `EVS_OFF_TRACE;
      `EVS_C_DECR:      win_off = `EVS_OFF_DECR;
      default:          win_off = `EVS_OFF_EXT;
    endcase
  end

  // base select
  wire [31:0] base = msw[MSW_VBASE] ? `EVS_BASE_HIGH : `EVS_BASE_LOW;
  wire [1:0]  ptype = c_pfloat ? `EVS_PT_FLOAT : c_priv ? `EVS_PT_PRIV :
                      c_trap ? `EVS_PT_TRAP : `EVS_PT_NONE;

  // ======================================================================
  // reset vector taken on the first cycle after release
  reg reset_done_ff;

  // take strobe, address and state word update
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_done_ff         <= 1'b0;
      take_ff               <= 1'b0;
      handler_addr_ff       <= 32'h00000000;
      program_type_ff       <= `EVS_PT_NONE;
      machine_state_word_ff <= 32'h00000000;
      ctrl_prev_ff          <= `EVS_CTRL_RESET;
      take_cnt_ff           <= 32'h00000000;
    end else begin
      take_ff      <= 1'b0;
      ctrl_prev_ff <= ctrl_w;
      // software update of gate, recoverable, base, user, float available
      if (ctrl_w != ctrl_prev_ff) begin
        machine_state_word_ff[MSW_GATE]  <= ctrl_w[0];
        machine_state_word_ff[MSW_RECOV] <= ctrl_w[1];
        machine_state_word_ff[MSW_VBASE] <= ctrl_w[2];
        machine_state_word_ff[MSW_USER]  <= ctrl_w[3];
        machine_state_word_ff[MSW_FAVL]  <= ctrl_w[4];
      end
      if (!reset_done_ff) begin
        reset_done_ff   <= 1'b1;
        take_ff         <= 1'b1;
        handler_addr_ff <= base + {12'h000, `EVS_OFF_RESET};
      end else if (win_any && !take_ff) begin
        take_ff         <= 1'b1;
        handler_addr_ff <= base + {12'h000, win_off};
        program_type_ff <= (win_idx == `EVS_C_PROGRAM) ? ptype : `EVS_PT_NONE;
        take_cnt_ff     <= take_cnt_ff + 32'h00000001;
        machine_state_word_ff[MSW_GATE]  <= 1'b0;
        machine_state_word_ff[MSW_RECOV] <= 1'b0;
      end
    end
  end

  // ======================================================================
  // async pending latches: set wins over clear by take
  // a decrementer edge served in its own cycle is not kept, so one edge gives one take
  wire dec_take = win_any && !take_ff && reset_done_ff && (win_idx == `EVS_C_DECR);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_ext_ff <= 1'b0;
      pend_dec_ff <= 1'b0;
    end else begin
      if (ext_req) begin
        pend_ext_ff <= 1'b1;
      end else if (win_any && !take_ff && reset_done_ff && win_idx == `EVS_C_EXT) begin
        pend_ext_ff <= 1'b0;
      end
      if (dec_rise && (pend_dec_ff || !dec_take)) begin
        pend_dec_ff <= 1'b1;
      end else if (dec_take) begin
        pend_dec_ff <= 1'b0;
      end
    end
  end
endmodule // evs_vector_select

//--- core/evs_map.vh
// constants for the exception vector select block
// ======================================================================
`ifndef EVS_MAP_VH
`define EVS_MAP_VH
// ======================================================================
// vector offsets
`define EVS_OFF_RESET     20'h00100
`define EVS_OFF_MCHECK    20'h00200
`define EVS_OFF_EXT       20'h00500
`define EVS_OFF_ALIGN     20'h00600
`define EVS_OFF_PROGRAM   20'h00700
`define EVS_OFF_FP_UNAV   20'h00800
`define EVS_OFF_DECR      20'h00900
`define EVS_OFF_SYSCALL   20'h00C00
`define EVS_OFF_TRACE     20'h00D00
`define EVS_OFF_FP_ASSIST 20'h00E00
`define EVS_OFF_SW_EMUL   20'h01000
`define EVS_OFF_DATA_BP   20'h01C00
`define EVS_OFF_INSTR_BP  20'h01D00
`define EVS_OFF_MEXT_BP   20'h01E00
`define EVS_OFF_NMEXT_BP  20'h01F00
// ======================================================================
// vector bases
`define EVS_BASE_LOW      32'h00000000
`define EVS_BASE_HIGH     32'hFFF00000
// ======================================================================
// cause indices, position is priority (0 highest)
`define EVS_NCAUSE        15
`define EVS_C_RESET       0
`define EVS_C_NMEXT_BP    1
`define EVS_C_MCHECK      2
`define EVS_C_INSTR_BP    3
`define EVS_C_DATA_BP     4
`define EVS_C_MEXT_BP     5
`define EVS_C_SW_EMUL     6
`define EVS_C_ALIGN       7
`define EVS_C_PROGRAM     8
`define EVS_C_FP_UNAV     9
`define EVS_C_SYSCALL     10
`define EVS_C_FP_ASSIST   11
`define EVS_C_TRACE       12
`define EVS_C_DECR        13
`define EVS_C_EXT         14
// ======================================================================
// program exception sub-type codes
`define EVS_PT_NONE       2'h0
`define EVS_PT_FLOAT      2'h1
`define EVS_PT_PRIV       2'h2
`define EVS_PT_TRAP       2'h3
// ======================================================================
// axi answers and register map
`define EVS_RESP_OKAY     2'h0
`define EVS_RESP_SLVERR   2'h2
`define EVS_REG_CTRL      12'h000
`define EVS_REG_STATUS    12'h004
`define EVS_REG_ADDR      12'h008
`define EVS_REG_COUNT     12'h00C
`define EVS_CTRL_RESET    5'h00
`define EVS_CTRL_W        5
`endif

//--- core/evs_sync2.v
// two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
module evs_sync2 #(
  parameter WIDTH = 4
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  // ======================================================================
  // stages
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      // first stage read only by second
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[gi];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = sync_ff;
    end
  endgenerate
endmodule // evs_sync2

//--- core/evs_axil_slave.v
// axi4-lite register slave for the exception vector select block
`timescale 1ns/100ps
`include "evs_map.vh"
module evs_axil_slave (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [4:0]  ctrl_ff,
  input  wire [31:0] status_in,
  input  wire [31:0] addr_in,
  input  wire [31:0] count_in
);
  // ======================================================================
  // write path: address and data caught in either order
  reg        aw_got_ff;
  reg        w_got_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  integer    bi;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 12'h000;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EVS_RESP_OKAY;
      ctrl_ff       <= `EVS_CTRL_RESET;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff     <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff     <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_ff && w_got_ff && !s_axi_bvalid) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({awaddr_ff[11:2], 2'h0} == `EVS_REG_CTRL) begin
          s_axi_bresp <= `EVS_RESP_OKAY;
          if (wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[4:0];
          end
        end else if ({awaddr_ff[11:2], 2'h0} == `EVS_REG_STATUS || {awaddr_ff[11:2], 2'h0} == `EVS_REG_ADDR ||
                     {awaddr_ff[11:2], 2'h0} == `EVS_REG_COUNT) begin
          s_axi_bresp <= `EVS_RESP_OKAY; // read-only, write ignored
        end else begin
          s_axi_bresp <= `EVS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EVS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b1 :
                       (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `EVS_RESP_OKAY;
        if ({s_axi_araddr[11:2], 2'h0} == `EVS_REG_CTRL) begin
          s_axi_rdata <= {27'h0000000, ctrl_ff};
        end else if ({s_axi_araddr[11:2], 2'h0} == `EVS_REG_STATUS) begin
          s_axi_rdata <= status_in;
        end else if ({s_axi_araddr[11:2], 2'h0} == `EVS_REG_ADDR) begin
          s_axi_rdata <= addr_in;
        end else if ({s_axi_araddr[11:2], 2'h0} == `EVS_REG_COUNT) begin
          s_axi_rdata <= count_in;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `EVS_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // evs_axil_slave

//--- tb/evs_props.sv
// assertions on the exception vector select outputs
`timescale 1ns/100ps
module evs_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        take_ff,
  input wire [31:0] handler_addr_ff,
  input wire [1:0]  program_type_ff,
  input wire [31:0] machine_state_word_ff,
  input wire        instr_valid,
  input wire        is_system_call_instr,
  input wire        devport_bp
);
  wire [19:0] off = handler_addr_ff[19:0];
  wire [31:0] sw  = machine_state_word_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ======================================================================
  // take strobe and handler address
  property p_pulse; take_ff |=> !take_ff; endproperty
  a_pulse: assert property (p_pulse) else $error("long take");
  property p_clr; take_ff |-> !sw[15] && !sw[1]; endproperty
  a_clr: assert property (p_clr) else $error("gate kept");
  property p_rsv; take_ff |-> !(off inside {20'h00400, 20'h00A00, 20'h00B00}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved vector");
  property p_base; take_ff |-> handler_addr_ff[31:20] == {12{sw[6]}}; endproperty
  a_base: assert property (p_base) else $error("bad base");
  property p_rst; $rose(aresetn) |-> ##[1:2] take_ff && off == 20'h00100; endproperty
  a_rst: assert property (p_rst) else $error("no reset vector");
  // ======================================================================
  // cause behind the vector
  property p_sc; take_ff && off == 20'h00C00 |-> $past(is_system_call_instr) && $past(instr_valid); endproperty
  a_sc: assert property (p_sc) else $error("syscall without cause");
  property p_priv; take_ff && program_type_ff == 2'h2 |-> $past(sw[14]); endproperty
  a_priv: assert property (p_priv) else $error("privileged outside user");
  property p_dev; $rose(devport_bp) |-> ##[2:8] take_ff && off == 20'h01F00; endproperty
  a_dev: assert property (p_dev) else $error("port break missed");
endmodule // evs_props

//--- tb/evs_far_model.sv
// far side: interrupt, bus error and breakpoint sources
`timescale 1ns/100ps
module evs_far_model (
  input  wire       aclk,
  input  wire [3:0] req,
  input  wire       slow,
  output wire       ext_irq_n,
  output wire       transfer_error_ack_n,
  output wire       mask_ext_bp,
  output wire       devport_bp
);
  reg  [3:0] d1_ff = 4'h0;
  reg  [3:0] d2_ff = 4'h0;
  wire [3:0] q     = slow ? d2_ff : d1_ff;
  // sources answer one or two cycles after the request
  always @(posedge aclk) begin
    d1_ff <= req;
    d2_ff <= d1_ff;
  end
  assign ext_irq_n            = !q[0];
  assign transfer_error_ack_n = !q[1];
  assign mask_ext_bp          = q[2];
  assign devport_bp           = q[3];
endmodule // evs_far_model

//--- tb/tb_evs_vector_select.sv
// self-checking bench of the exception vector select block
`timescale 1ns/100ps
module tb_evs_vector_select;
  reg         aclk = 1'h0, aresetn = 1'h0, instr_valid = 1'h0, slow = 1'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg  [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg  [31:0] s_axi_wdata = 32'h0, down_counter_reg = 32'h0, last_ha = 32'h0, rs = 32'h41;
  reg  [18:0] pf = 19'h0;
  reg  [9:0]  special_register_number_field = 10'h0;
  reg  [3:0]  req = 4'h0;
  reg  [1:0]  last_pt = 2'h0;
  reg  [45:0] c;
  wire [3:0]  s_axi_wstrb = 4'hF;
  wire        instr_completed = 1'h0, is_intr_return = 1'h0, is_branch = 1'h0;
  wire        float_summary_enabled_flag = 1'h0;
  wire        is_float_ldst = pf[0], is_ldst_multiple = pf[1], is_string = pf[2];
  wire        is_reserving_load_instr = pf[3], is_cond_store = pf[4], operand_word_misaligned = pf[5];
  wire        operand_le_misaligned = pf[6], is_float_instr = pf[7], float_state_move = pf[8];
  wire        is_privileged = pf[9], spr_move = pf[10], spr_invalid = pf[11], spr_unimpl = pf[12];
  wire        trap_cond_true = pf[13], is_system_call_instr = pf[14], float_assist_cond = pf[15];
  wire        unimpl_instr = pf[16], data_bp_match = pf[17], instr_bp_match = pf[18];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, take_ff;
  wire        ext_irq_n, transfer_error_ack_n, mask_ext_bp, devport_bp;
  wire [1:0]  s_axi_bresp, s_axi_rresp, program_type_ff;
  wire [31:0] s_axi_rdata, handler_addr_ff, machine_state_word_ff;
  integer     bad_count = 0, tests_run = 0, ntk = 0, seen = 0, k, n;
  evs_vector_select evs_vector_select_i (.*);
  evs_far_model     evs_far_model_i (.*);
  always #12.5 aclk = ~aclk;
  // count takes, keep the last vector
  always @(posedge aclk) begin
    if (take_ff) begin
      ntk <= ntk + 1;
      last_ha <= handler_addr_ff;
      last_pt <= program_type_ff;
    end
  end
  // ======================================================================
  // helpers
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // flags, control, offset, program type
  function [45:0] cs(input integer i);
    case (i)
      0: cs = {19'h04000, 5'h00, 20'h00C00, 2'h0};
      1: cs = {19'h10000, 5'h00, 20'h01000, 2'h0};
      2: cs = {19'h01400, 5'h00, 20'h01000, 2'h0};
      3: cs = {19'h00200, 5'h08, 20'h00700, 2'h2};
      4: cs = {19'h00C00, 5'h08, 20'h00700, 2'h2};
      5: cs = {19'h02000, 5'h00, 20'h00700, 2'h3};
      6: cs = {19'h00080, 5'h00, 20'h00800, 2'h0};
      7: cs = {19'h00021, 5'h10, 20'h00600, 2'h0};
      8: cs = {19'h00022, 5'h10, 20'h00600, 2'h0};
      9: cs = {19'h00028, 5'h10, 20'h00600, 2'h0};
      10: cs = {19'h08000, 5'h10, 20'h00E00, 2'h0};
      11: cs = {19'h20000, 5'h02, 20'h01C00, 2'h0};
      default: cs = {19'h40000, 5'h02, 20'h01D00, 2'h0};
    endcase
  endfunction
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tmo;
    begin
      $display("mismatch at %0t: wait ran out", $time);
      bad_count = bad_count + 1;
      results;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; !s_axi_bvalid; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (n > 40) tmo;
      end
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, 2'h0);
      @(posedge aclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; !s_axi_rvalid; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (n > 40) tmo;
      end
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, er);
      @(posedge aclk);
    end
  endtask
  task setc(input [4:0] v);
    begin
      seen = ntk;
      wr(12'h000, 32'h0);
      wr(12'h000, {27'h0, v});
    end
  endtask
  task wt(input [31:0] ea, input [1:0] et);
    begin
      for (n = 0; ntk == seen; n = n + 1) begin
        @(posedge aclk);
        if (n > 40) tmo;
      end
      seen = ntk;
      chk(last_ha, ea);
      chk(last_pt, et);
    end
  endtask
  // ======================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wt(32'h100, 2'h0);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h010, 32'h0, 2'h2);
    wr(12'h004, rs);
    for (k = 0; k < 13; k = k + 1) begin
      rs = xs(rs);
      c = cs(k);
      setc(c[26:22] | {rs[0], 2'h0});
      pf <= c[45:27];
      instr_valid <= 1'h1;
      special_register_number_field <= {1'h1, rs[9:1]};
      @(posedge aclk);
      pf <= 19'h0;
      instr_valid <= 1'h0;
      wt({{12{rs[0]}}, c[21:2]}, c[1:0]);
    end
    setc(5'h01);
    down_counter_reg <= {1'h1, rs[30:0]};
    wt(32'h900, 2'h0);
    down_counter_reg <= 32'h0;
    for (k = 1; k < 4; k = k + 1) begin
      rs = xs(rs);
      setc(k == 2 ? 5'h02 : 5'h00);
      slow <= rs[1];
      req <= 4'h1 << k;
      wt(k == 1 ? 32'h200 : 32'h1C00 + (k << 8), 2'h0);
      req <= 4'h0;
      repeat (8) @(posedge aclk);
    end
    setc(5'h00);
    req <= 4'h1;
    n = ntk;
    repeat (12) @(posedge aclk);
    chk(ntk - n, 0);
    setc(5'h01);
    wt(32'h500, 2'h0);
    req <= 4'h0;
    rd(12'h008, 32'h500, 2'h0);
    rd(12'h004, 32'h00080000, 2'h0);
    results;
  end
endmodule // tb_evs_vector_select
bind evs_vector_select evs_props evs_props_i (.*);
